/* src/ccc_core.sv */
// core configuration control register bank with its controlled logic
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "ccc_consts.svh"
module ccc_core import ccc_pkg::*; #(
    parameter int AW = `CCC_ADDR_W,
    parameter int TB_DIV = `CCC_TB_DIV
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic mcheck_in,
    input wire logic ext_irq_taken,
    input wire logic crit_irq_taken,
    input wire logic debug_irq_taken,
    input wire logic resv_set,
    input wire logic resv_clear,
    input wire logic wake,
    input wire logic tb_ext_clk,
    input wire logic br_valid,
    input wire logic br_disp_msb,
    input wire logic absolute_address_flag,
    output logic mcheck_irq_q,
    output logic checkstop_q,
    output logic resv_valid_q,
    output logic br_accel_q,
    output logic [2:0] low_power_q,
    output logic irq_q
);
    if (AW < 5 || AW > 16) begin : g_aw_check
        $error("AW out of range");
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] strb
    );
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic is_ofs(
        input logic [AW-1:0] a,
        input logic [7:0] ofs
    );
        is_ofs = (a == AW'(ofs));
    endfunction

    // ----------------------------------------
    // bus front end
    // ----------------------------------------
    logic wr_en, rd_en, wr_hit, rd_hit;
    logic [AW-1:0] wr_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;

    ccc_axil_slave #(.AW(AW)) u_bus (
        .clk(clk),
        .sys_rst(sys_rst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_hit(wr_hit),
        .rd_en(rd_en),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [31:0] cfg_q, cfg_d;
    logic [2:0] state_q, state_d;
    logic [`CCC_STS_W-1:0] sts_q, sts_d, mask_q, mask_d;
    logic [`CCC_STS_W-1:0] sts_set;
    logic [63:0] tb_q, tb_d;
    logic [31:0] dec_q, dec_d;
    ccc_pwr_t pwr_q, pwr_d;
    logic mc_prev_q;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    logic wr_cfg, wr_state, wr_sts, wr_mask, wr_tb_lo, wr_tb_hi, wr_dec;
    assign wr_cfg = wr_en & is_ofs(wr_addr, `CCC_OFS_CFG);
    assign wr_state = wr_en & is_ofs(wr_addr, `CCC_OFS_STATE);
    assign wr_sts = wr_en & is_ofs(wr_addr, `CCC_OFS_STS);
    assign wr_mask = wr_en & is_ofs(wr_addr, `CCC_OFS_MASK);
    assign wr_tb_lo = wr_en & is_ofs(wr_addr, `CCC_OFS_TB_LO);
    assign wr_tb_hi = wr_en & is_ofs(wr_addr, `CCC_OFS_TB_HI);
    assign wr_dec = wr_en & is_ofs(wr_addr, `CCC_OFS_DEC);
    // the status word is read-only except for its clear bits
    assign wr_hit = wr_cfg | wr_state | wr_sts | wr_mask | wr_tb_lo
        | wr_tb_hi | wr_dec;

    // ----------------------------------------
    // config fields
    // ----------------------------------------
    logic mc_en, resv_clr_en, tb_en, tb_sel, dbg_clr_ee;
    logic doze_sel, nap_sel, sleep_sel;
    logic [1:0] bac;
    assign mc_en = cfg_q[`CCC_B_MCIE];
    assign bac = cfg_q[`CCC_B_BAC_HI:`CCC_B_BAC_LO];
    assign doze_sel = cfg_q[`CCC_B_DOZE];
    assign nap_sel = cfg_q[`CCC_B_NAP];
    assign sleep_sel = cfg_q[`CCC_B_SLEEP];
    assign resv_clr_en = cfg_q[`CCC_B_RESV_CLR];
    assign tb_en = cfg_q[`CCC_B_TB_EN];
    assign tb_sel = cfg_q[`CCC_B_TBSEL];
    assign dbg_clr_ee = cfg_q[`CCC_B_DBG_CLR_EE];

    assign cfg_d = wr_cfg ? (merge(cfg_q, wr_data, wr_strb)
        & `CCC_CFG_WMASK) : cfg_q;

    // ----------------------------------------
    // machine check
    // ----------------------------------------
    logic mc_edge, mc_take, mc_stop;
    assign mc_edge = mcheck_in & ~mc_prev_q;
    assign mc_take = mc_edge & mc_en & state_q[`CCC_B_ME];
    assign mc_stop = mc_edge & mc_en & ~state_q[`CCC_B_ME];

    // ----------------------------------------
    // reservation
    // ----------------------------------------
    logic irq_any, resv_drop;
    assign irq_any = ext_irq_taken | crit_irq_taken;
    assign resv_drop = irq_any & resv_clr_en & resv_valid_q;

    // ----------------------------------------
    // machine state word
    // ----------------------------------------
    logic ee_drop, we_drop;
    assign ee_drop = debug_irq_taken & dbg_clr_ee & state_q[`CCC_B_EE];
    // waking ends the wait, so a later set of wait re-enters
    assign we_drop = wake & (pwr_q != CCC_PWR_RUN);

    always_comb begin
        state_d = wr_state ? wr_data[2:0] : state_q;
        if (ee_drop) begin
            state_d[`CCC_B_EE] = 1'b0;
        end
        if (we_drop) begin
            state_d[`CCC_B_WE] = 1'b0;
        end
    end

    // ----------------------------------------
    // power management
    // ----------------------------------------
    logic pwr_enter;
    ccc_pwr_t pwr_pick;
    // deepest selection wins if software breaks the one-hot setting
    // doze, nap or sleep entry
    assign pwr_pick = sleep_sel ? CCC_PWR_SLEEP :
        nap_sel ? CCC_PWR_NAP :
        doze_sel ? CCC_PWR_DOZE : CCC_PWR_RUN;
    assign pwr_enter = state_q[`CCC_B_WE] & (pwr_q == CCC_PWR_RUN)
        & (pwr_pick != CCC_PWR_RUN) & ~wake;

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            CCC_PWR_RUN: begin
                if (pwr_enter) begin
                    pwr_d = pwr_pick;
                end
            end
            CCC_PWR_DOZE, CCC_PWR_NAP, CCC_PWR_SLEEP: begin
                if (wake) begin
                    pwr_d = CCC_PWR_RUN;
                end
            end
            default: begin
                pwr_d = CCC_PWR_RUN;
            end
        endcase
    end

    // ----------------------------------------
    // time base and decrementer
    // ----------------------------------------
    logic tb_tick, dec_zero;

    ccc_tb_tick #(.DIV(TB_DIV)) u_tick (
        .clk(clk),
        .sys_rst(sys_rst),
        .enable(tb_en),
        .sel_ext(tb_sel),
        .ext_clk(tb_ext_clk),
        .tick(tb_tick)
    );

    assign dec_zero = tb_tick & (dec_q == 32'h0000_0001);

    // a software write in a tick cycle wins over the tick in the half that is written
    always_comb begin
        tb_d = tb_q;
        if (tb_tick) begin
            tb_d = tb_q + 64'h0000_0000_0000_0001;
        end
        if (wr_tb_lo) begin
            tb_d[31:0] = merge(tb_q[31:0], wr_data, wr_strb);
        end
        if (wr_tb_hi) begin
            tb_d[63:32] = merge(tb_q[63:32], wr_data, wr_strb);
        end
    end

    // decrementer stops at zero
    assign dec_d = wr_dec ? merge(dec_q, wr_data, wr_strb) :
        (tb_tick && dec_q != 32'h0000_0000) ? dec_q - 32'h0000_0001 :
        dec_q;

    // ----------------------------------------
    // events and interrupt
    // ----------------------------------------
    always_comb begin
        sts_set = '0;
        sts_set[`CCC_EV_MCIRQ] = mc_take;
        sts_set[`CCC_EV_CHKSTOP] = mc_stop;
        sts_set[`CCC_EV_DEC] = dec_zero;
        sts_set[`CCC_EV_RESV] = resv_drop;
        sts_set[`CCC_EV_DBGEE] = ee_drop;
        sts_set[`CCC_EV_PWR] = pwr_enter;
    end

    // set wins over a same-cycle clear
    assign sts_d = (sts_q & ~((wr_sts ? wr_data[`CCC_STS_W-1:0] : '0)))
        | sts_set;
    assign mask_d = wr_mask ? wr_data[`CCC_STS_W-1:0] : mask_q;

    // ----------------------------------------
    // branch acceleration
    // ----------------------------------------
    logic br_backward, br_ok;
    // msb is direction, absolute or not
    assign br_backward = br_disp_msb;
    assign br_ok = br_valid & ~(br_backward ? bac[0] : bac[1]);

    // ----------------------------------------
    // read decode
    // ----------------------------------------
    logic [31:0] pstat;
    assign pstat = {24'h00_0000, 2'(pwr_q), checkstop_q, resv_valid_q,
        absolute_address_flag & br_valid, 3'h0};
    assign rd_hit = is_ofs(s_axi_araddr, `CCC_OFS_CFG)
        | is_ofs(s_axi_araddr, `CCC_OFS_STATE)
        | is_ofs(s_axi_araddr, `CCC_OFS_STS)
        | is_ofs(s_axi_araddr, `CCC_OFS_MASK)
        | is_ofs(s_axi_araddr, `CCC_OFS_TB_LO)
        | is_ofs(s_axi_araddr, `CCC_OFS_TB_HI)
        | is_ofs(s_axi_araddr, `CCC_OFS_DEC)
        | is_ofs(s_axi_araddr, `CCC_OFS_PSTAT);
    assign rd_data =
        is_ofs(s_axi_araddr, `CCC_OFS_CFG) ? cfg_q :
        is_ofs(s_axi_araddr, `CCC_OFS_STATE) ? {29'h0, state_q} :
        is_ofs(s_axi_araddr, `CCC_OFS_STS) ? {26'h0, sts_q} :
        is_ofs(s_axi_araddr, `CCC_OFS_MASK) ? {26'h0, mask_q} :
        is_ofs(s_axi_araddr, `CCC_OFS_TB_LO) ? tb_q[31:0] :
        is_ofs(s_axi_araddr, `CCC_OFS_TB_HI) ? tb_q[63:32] :
        is_ofs(s_axi_araddr, `CCC_OFS_DEC) ? dec_q :
        is_ofs(s_axi_araddr, `CCC_OFS_PSTAT) ? pstat : 32'h0000_0000;

    // ----------------------------------------
    // state flops
    // ----------------------------------------
    // reset clears every field
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_q <= `CCC_CFG_RST;
            state_q <= `CCC_STATE_RST;
            sts_q <= '0;
            mask_q <= '0;
            tb_q <= 64'h0000_0000_0000_0000;
            dec_q <= 32'h0000_0000;
            pwr_q <= CCC_PWR_RUN;
            mc_prev_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            state_q <= state_d;
            sts_q <= sts_d;
            mask_q <= mask_d;
            tb_q <= tb_d;
            dec_q <= dec_d;
            pwr_q <= pwr_d;
            mc_prev_q <= mcheck_in;
        end
    end

    // ----------------------------------------
    // output flops
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mcheck_irq_q <= 1'b0;
            checkstop_q <= 1'b0;
            resv_valid_q <= 1'b0;
            br_accel_q <= 1'b0;
            low_power_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            mcheck_irq_q <= mc_take;
            // checkstop holds until reset
            checkstop_q <= checkstop_q | mc_stop;
            resv_valid_q <= (resv_valid_q | resv_set)
                & ~resv_clear & ~(irq_any & resv_clr_en);
            br_accel_q <= br_ok;
            low_power_q <= {pwr_d == CCC_PWR_SLEEP, pwr_d == CCC_PWR_NAP,
                pwr_d == CCC_PWR_DOZE};
            irq_q <= |(sts_d & mask_d);
        end
    end
endmodule

/* include/ccc_consts.svh */
// offsets, field positions, reset values and counts of the config block
`ifndef CCC_CONSTS_SVH
`define CCC_CONSTS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define CCC_ADDR_W 8
`define CCC_OFS_CFG 8'h00
`define CCC_OFS_STATE 8'h04
`define CCC_OFS_STS 8'h08
`define CCC_OFS_MASK 8'h0C
`define CCC_OFS_TB_LO 8'h10
`define CCC_OFS_TB_HI 8'h14
`define CCC_OFS_DEC 8'h18
`define CCC_OFS_PSTAT 8'h1C
// ----------------------------------------
// config word fields (bit 31 is data bit 31)
// ----------------------------------------
`define CCC_B_MCIE 31
`define CCC_B_BAC_HI 25
`define CCC_B_BAC_LO 24
`define CCC_B_DOZE 23
`define CCC_B_NAP 22
`define CCC_B_SLEEP 21
`define CCC_B_RESV_CLR 17
`define CCC_B_SW_FLAG 16
`define CCC_B_TB_EN 14
`define CCC_B_TBSEL 13
`define CCC_B_DBG_CLR_EE 12
`define CCC_CFG_WMASK 32'h83E3_7000
`define CCC_CFG_RST 32'h0000_0000
// ----------------------------------------
// state word fields and status events
// ----------------------------------------
`define CCC_B_ME 0
`define CCC_B_WE 1
`define CCC_B_EE 2
`define CCC_STATE_RST 3'h0
`define CCC_STS_W 6
`define CCC_EV_MCIRQ 0
`define CCC_EV_CHKSTOP 1
`define CCC_EV_DEC 2
`define CCC_EV_RESV 3
`define CCC_EV_DBGEE 4
`define CCC_EV_PWR 5
`define CCC_TB_DIV 1
`endif

/* include/ccc_pkg.sv */
// types shared by the config control block
package ccc_pkg;
    typedef enum logic [1:0] {
        CCC_PWR_RUN,
        CCC_PWR_DOZE,
        CCC_PWR_NAP,
        CCC_PWR_SLEEP
    } ccc_pwr_t;
    typedef enum logic [1:0] {CCC_RESP_OKAY, CCC_RESP_EXOKAY,
        CCC_RESP_SLVERR, CCC_RESP_DECERR} ccc_resp_t;
endpackage

/* src/ccc_axil_slave.sv */
// axi4-lite slave front end of the config block
`timescale 1ns/1ps
`include "ccc_consts.svh"
module ccc_axil_slave import ccc_pkg::*; #(
    parameter int AW = `CCC_ADDR_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [AW-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_hit,
    output logic rd_en,
    input wire logic [31:0] rd_data,
    input wire logic rd_hit
);
    logic aw_have_q, w_have_q;
    logic aw_take, w_take, ar_take;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign ar_take = s_axi_arvalid & s_axi_arready;
    // one write at a time: commit only when both halves are held
    assign wr_en = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign rd_en = ar_take;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            wr_addr <= '0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_en) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? CCC_RESP_OKAY : CCC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_have_q & ~aw_take & ~s_axi_bvalid;
            s_axi_wready <= ~w_have_q & ~w_take & ~s_axi_bvalid;
            s_axi_arready <= ~ar_take & ~s_axi_rvalid;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_data : 32'h0000_0000;
            s_axi_rresp <= rd_hit ? CCC_RESP_OKAY : CCC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* src/ccc_tb_tick.sv */
// time-base tick source: divided core clock or edge of the ext clock
`timescale 1ns/1ps
module ccc_tb_tick #(
    parameter int DIV = 1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic sel_ext,
    input wire logic ext_clk,
    output logic tick
);
    logic [15:0] div_q;
    logic ext_prev_q;
    logic div_hit;
    if (DIV < 1 || DIV > 65535) begin : g_div_check
        $error("DIV out of range");
    end
    assign div_hit = (div_q == 16'(DIV - 1));
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_q <= 16'h0000;
            ext_prev_q <= 1'b0;
            tick <= 1'b0;
        end else begin
            ext_prev_q <= ext_clk;
            div_q <= div_hit ? 16'h0000 : div_q + 16'h0001;
            // ext clock is slow against clk, so one rising edge is one tick
            tick <= enable & (sel_ext ? (ext_clk & ~ext_prev_q) : div_hit);
        end
    end
endmodule

/* verif/ccc_core_asserts.sv */
// port assertions of the config control block
`timescale 1ns/1ps
module ccc_asserts (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic mcheck_in,
    input wire logic ext_irq_taken,
    input wire logic crit_irq_taken,
    input wire logic resv_set,
    input wire logic resv_clear,
    input wire logic wake,
    input wire logic br_valid,
    input wire logic mcheck_irq_q,
    input wire logic checkstop_q,
    input wire logic resv_valid_q,
    input wire logic br_accel_q,
    input wire logic [2:0] low_power_q,
    input wire logic irq_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_resv_made;
        resv_set && !resv_clear && !ext_irq_taken && !crit_irq_taken;
    endsequence
    sequence s_resv_held;
        ##1 resv_valid_q;
    endsequence
    property p_mc_cause;
        mcheck_irq_q |-> $past(mcheck_in) && !$past(mcheck_in, 2);
    endproperty
    a_mc_cause: assert property (p_mc_cause)
        else $error("irq without input edge");
    property p_cs_hold; checkstop_q |=> checkstop_q; endproperty
    a_cs_hold: assert property (p_cs_hold)
        else $error("checkstop dropped");
    property p_br; br_accel_q |-> $past(br_valid); endproperty
    a_br: assert property (p_br)
        else $error("accel without lookup");
    property p_lp_one; $onehot0(low_power_q); endproperty
    a_lp_one: assert property (p_lp_one)
        else $error("two power states");
    property p_wake; wake |=> low_power_q == 3'h0; endproperty
    a_wake: assert property (p_wake)
        else $error("no run after wake");
    property p_resv; s_resv_made |-> s_resv_held; endproperty
    a_resv: assert property (p_resv)
        else $error("reservation lost");
    // a reset also drops the reservation, so that edge is left out
    property p_resv_drop;
        $fell(resv_valid_q) && !$past(sys_rst)
            |-> $past(resv_clear | ext_irq_taken | crit_irq_taken);
    endproperty
    a_resv_drop: assert property (p_resv_drop)
        else $error("reservation dropped alone");
    property p_rst;
        disable iff (1'b0) sys_rst |=> !irq_q && !checkstop_q && !low_power_q;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs set in reset");
endmodule

/* verif/ccc_far_model.sv */
// far-side model: external time-base clock source
`timescale 1ns/1ps
module ccc_far_model (
    input wire logic clk,
    input wire logic run,
    output logic tb_ext_clk
);
    logic [3:0] div_q = 4'h0;
    assign tb_ext_clk = run & div_q[3];
    always_ff @(posedge clk) begin
        div_q <= div_q + 4'h1;
    end
endmodule

/* verif/tb_core_config_control_register.sv */
// self-checking bench for the config control block
`timescale 1ns/1ps
module tb_core_config_control_register import ccc_pkg::*;;
    logic clk = 1'b0, sys_rst = 1'b1, br_valid = 1'b0, br_disp_msb = 1'b0;
    logic absolute_address_flag = 1'b0, ext_run = 1'b0, tb_ext_clk;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, eb[$];
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, mcheck_irq_q, checkstop_q, resv_valid_q;
    logic br_accel_q, irq_q;
    logic [2:0] low_power_q;
    logic [6:0] ev = 7'h00, o;
    logic [33:0] er[$];
    int n_mismatch = 0, num_checks = 0, cyc = 0, n_mci = 0;
    initial forever #4 clk = ~clk;
    ccc_core dut (.*, .mcheck_in(ev[0]), .ext_irq_taken(ev[1]),
        .crit_irq_taken(ev[2]), .debug_irq_taken(ev[3]), .resv_set(ev[4]),
        .wake(ev[5]), .resv_clear(ev[6]));
    ccc_far_model far (.clk, .run(ext_run), .tb_ext_clk);
    task automatic cmp(logic [33:0] g, logic [33:0] e);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic see(int i, logic e);
        cmp({33'h0, o[i]}, {33'h0, e});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // one transfer; the answer is awaited with no fixed latency
    task automatic bus(bit w, logic [7:0] a, logic [31:0] d,
            logic [1:0] r = 2'h0);
        bit ha, hw, hd;
        if (w) eb.push_back(r);
        else er.push_back({r, d});
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(negedge clk);
            ha = w ? s_axi_awready : s_axi_arready;
            hw = s_axi_wready;
            hd = w ? s_axi_bvalid : s_axi_rvalid;
            @(posedge clk);
            if (ha) {s_axi_awvalid, s_axi_arvalid} <= 2'b00;
            if (hw) s_axi_wvalid <= 1'b0;
        end while (!hd);
        {s_axi_bready, s_axi_rready} <= 2'b00;
        repeat (2) @(posedge clk);
    endtask
    task automatic pulse(int i);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // outputs are snapshot off the edge so checks never race the design
    always @(negedge clk) begin
        o <= {irq_q, checkstop_q, resv_valid_q, br_accel_q, low_power_q};
        // the interrupt is a one-cycle pulse, so it is counted here
        if (mcheck_irq_q === 1'b1) n_mci++;
        if (s_axi_bvalid && s_axi_bready)
            cmp({32'h0, s_axi_bresp}, {32'h0, eb.pop_front()});
        if (s_axi_rvalid && s_axi_rready)
            cmp({s_axi_rresp, s_axi_rdata}, er.pop_front());
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial begin
        logic [31:0] v;
        v = $urandom(32'h638E33C8);
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 32; a += 4)
            bus(0, 8'(a), 32'h0);
        v = $urandom & 32'h8303_7000;
        bus(1, 8'h00, v);
        bus(0, 8'h00, v);
        bus(0, 8'h20, 32'h0, 2'h2);
        bus(1, 8'h00, 32'h0);
        bus(1, 8'h04, 32'h1);
        pulse(0);
        bus(0, 8'h08, 32'h0);
        cmp(34'(n_mci), 34'h0);
        bus(1, 8'h00, 32'h8000_0000);
        pulse(0);
        bus(0, 8'h08, 32'h1);
        cmp(34'(n_mci), 34'h1);
        see(6, 1'b0);
        bus(1, 8'h0C, 32'h1);
        see(6, 1'b1);
        bus(1, 8'h08, 32'h1);
        see(6, 1'b0);
        bus(1, 8'h04, 32'h0);
        pulse(0);
        see(5, 1'b1);
        br_valid <= 1'b1;
        for (int f = 0; f < 8; f++) begin
            br_disp_msb <= f[0];
            absolute_address_flag <= 1'($urandom);
            bus(1, 8'h00, {6'h0, f[2:1], 24'h0});
            see(3, !(f[1] && f[0] || f[2] && !f[0]));
        end
        for (int i = 0; i < 3; i++) begin
            bus(1, 8'h00, 32'h0080_0000 >> i);
            bus(1, 8'h04, 32'h2);
            see(i, 1'b1);
            pulse(5);
            see(i, 1'b0);
        end
        pulse(4);
        see(4, 1'b1);
        pulse(1);
        see(4, 1'b1);
        bus(1, 8'h00, 32'h0002_0000);
        pulse(2);
        see(4, 1'b0);
        bus(1, 8'h00, 32'h1000);
        bus(1, 8'h04, 32'h4);
        pulse(3);
        bus(0, 8'h04, 32'h0);
        bus(1, 8'h18, 32'h3);
        repeat (20) @(posedge clk);
        bus(0, 8'h18, 32'h3);
        bus(1, 8'h00, 32'h2000);
        bus(1, 8'h00, 32'h6000);
        repeat (20) @(posedge clk);
        bus(0, 8'h18, 32'h3);
        ext_run <= 1'b1;
        repeat (80) @(posedge clk);
        bus(0, 8'h18, 32'h0);
        // checkstop, decrementer, reservation, debug and power events
        bus(0, 8'h08, 32'h3E);
        bus(1, 8'h00, 32'h2000);
        bus(1, 8'h00, 32'h0);
        bus(1, 8'h18, 32'h5);
        bus(1, 8'h00, 32'h4000);
        repeat (20) @(posedge clk);
        bus(0, 8'h18, 32'h0);
        tally_and_finish;
    end
endmodule
bind ccc_core ccc_asserts chk (.*);
